/* File: hdl/rcl_pkg.sv */
// Package with shared constants and types for the reset configuration and lock-step block.
package rcl_pkg;

  // APB register byte offsets.
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_REGION0 = 8'h0c;
  localparam logic [7:0] OFF_REGION1 = 8'h10;

  // Per-CPU control field positions.
  localparam int CTRL_W = 13;
  localparam int EXCEPTION_ENDIAN_BIT = 0;
  localparam int EXCEPTION_STATE_BIT = 1;
  localparam int HIGH_VECTORS_BIT = 2;
  localparam int TCM_A_CHECK_ENABLE = 3;
  localparam int TCM_B_BANK0_CHECK_ENABLE = 4;
  localparam int TCM_B_BANK1_CHECK_ENABLE = 5;
  localparam int TCM_A_EXT_ERROR_ENABLE = 6;
  localparam int TCM_B_BANK0_EXT_ERROR_ENABLE = 7;
  localparam int TCM_B_BANK1_EXT_ERROR_ENABLE = 8;
  localparam int TCM_A_RMW_ENABLE = 9;
  localparam int TCM_B_RMW_ENABLE = 10;
  localparam int PRIMARY_PERIPH_REGION_ENABLE = 11;
  localparam int SECONDARY_PERIPH_REGION_ENABLE = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0000;

  // Status register field positions.
  localparam int STAT_LOCKED_BIT = 0;
  localparam int STAT_MISMATCH_BIT = 1;
  localparam int STAT_FAULT_BIT = 2;
  localparam int STAT_ARRANGE_LSB = 3;

  // Region register layout and size limits, as log2 of bytes.
  localparam int REGION_BASE_LSB = 12;
  localparam logic [5:0] REGION_LOG2_MIN = 6'h0c;
  localparam logic [5:0] REGION_LOG2_MAX = 6'h20;

  // Comparator bus bit use.
  localparam int CMP_CLEAR_BIT = 0;
  localparam int CMP_TEST_BIT = 0;
  localparam int CMP_OUT_LOCKED = 0;
  localparam int CMP_OUT_MISMATCH = 1;
  localparam int CMP_OUT_FAULT = 2;

  typedef enum logic [1:0] {RCL_SINGLE, RCL_TWIN, RCL_REDUNDANT, RCL_SPLITLOCK} rcl_arrange_t;
  typedef enum logic {PH_RESET, PH_RUN} rcl_phase_t;

  // Tie-off pins for one CPU.
  typedef struct packed {
    logic [CTRL_W-1:0] preset;
    logic bank1Used;
    logic [5:0] regionLog2;
    logic [19:0] regionBase;
  } rcl_strap_t;

  // Coherency port request.
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } rcl_coh_t;

endpackage

/* File: hdl/rcl_top.sv */
// Reset-time configuration loader and CPU arrangement control for a two-CPU group.
`timescale 1ns/1ps
// Function
// - Exception endianness preset from pin at reset.
// - Exception instruction state preset from pin.
// - Vector base low or high, pin preset.
// - One check enable covers both second-memory banks.
// - Separate external error enables, all preset.
// - Check enable only with matching scheme, ports.
// - Read-modify-write enable only without word ECC.
// - Secondary region enable only if port built.
// - Each CPU has own configuration copy.
// - Virtual region size power-of-two, base aligned.
// - Shared coherency port coherent with both CPUs.
// - No hardware coherency between CPU caches.
// - Redundant copy gets identical inputs, lock-step.
// - Only functional CPU drives outputs, RAMs.
// - Redundant copy shares functional cache RAMs.
// - Comparator flags any single output mismatch.
// - Comparators use two 8-bit in/out buses.
// - Split gives twin CPUs, locked gives redundant.
// - Mode inputs change only under power-on reset.
// - Coherency port logic duplicated when redundant.
module rcl_top import rcl_pkg::*; #(
  parameter rcl_arrange_t ARRANGEMENT = RCL_SPLITLOCK,
  parameter int IO_W = 32,
  parameter int RAM_W = 64,
  parameter int unsigned TCM_B_PORTS = 2,
  parameter bit TCM_A_PRESENT = 1'b1,
  parameter bit TCM_A_ECC = 1'b1,
  parameter bit TCM_A_ECC32 = 1'b0,
  parameter bit TCM_B_ECC = 1'b1,
  parameter bit TCM_B_ECC32 = 1'b0,
  parameter bit SECONDARY_PORT = 1'b1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // APB register slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Tie-off pins and mode selects.
  input wire rcl_strap_t [1:0] strapPins,
  input wire logic splitModeSelect,
  input wire logic lockClampSelect,
  // Control fields and regions per CPU.
  output logic [1:0][CTRL_W-1:0] ctrlFields,
  output logic [1:0][31:0] periphRegionBase,
  output logic [1:0][5:0] periphRegionLog2,
  output logic lockedMode,
  // System side of each CPU.
  input wire logic [IO_W-1:0] cpu0In,
  input wire logic [IO_W-1:0] cpu1In,
  output logic [IO_W-1:0] groupOut0,
  output logic [IO_W-1:0] groupOut1,
  // Core side of each CPU.
  output logic [IO_W-1:0] cpu0CoreIn,
  output logic [IO_W-1:0] cpu1CoreIn,
  input wire logic [IO_W-1:0] cpu0Out,
  input wire logic [IO_W-1:0] cpu1Out,
  // Cache RAM ports.
  input wire logic [RAM_W-1:0] cpu0RamReq,
  input wire logic [RAM_W-1:0] cpu1RamReq,
  output logic [RAM_W-1:0] ram0Req,
  output logic [RAM_W-1:0] ram1Req,
  input wire logic [RAM_W-1:0] ram0Rdata,
  input wire logic [RAM_W-1:0] ram1Rdata,
  output logic [RAM_W-1:0] cpu0RamRdata,
  output logic [RAM_W-1:0] cpu1RamRdata,
  // Comparator status buses.
  input wire logic [7:0] compareInA,
  input wire logic [7:0] compareInB,
  output logic [7:0] compareOutA,
  output logic [7:0] compareOutB,
  // Coherency port.
  input wire logic coherencyValid,
  input wire logic [31:0] coherencyAddr,
  output logic [1:0] snoopValid,
  output logic [31:0] snoopAddr
);

  typedef struct packed {
    rcl_phase_t phase;
    rcl_strap_t [1:0] strapMeta;
    rcl_strap_t [1:0] strapSync;
    rcl_strap_t [1:0] strapLatched;
    logic [1:0][CTRL_W-1:0] ctrl;
    logic [1:0] modeMeta;
    logic [1:0] modeSync;
    logic lockedMode;
    logic [1:0] cmpMeta;
    logic [1:0] cmpSync;
    logic mismatch;
    logic fault;
    logic [IO_W-1:0] cpu0CoreIn;
    logic [IO_W-1:0] cpu1CoreIn;
    logic [IO_W-1:0] groupOut0;
    logic [IO_W-1:0] groupOut1;
    logic [RAM_W-1:0] ram0Req;
    logic [RAM_W-1:0] ram1Req;
    logic [RAM_W-1:0] cpu0RamRdata;
    logic [RAM_W-1:0] cpu1RamRdata;
    rcl_coh_t cohFunc;
    rcl_coh_t cohRed;
    logic [31:0] prdata;
    logic pslverr;
  } rcl_state_t;

  rcl_state_t st;
  rcl_state_t next_st;
  logic isLocked;
  logic cpu1Active;
  logic hasRedundant;
  logic mismatchNow;
  logic apbWrite;
  logic [1:0][31:0] regionBase;
  logic [1:0][5:0] regionLog2;

  // Which check, error and mode enables this build and pin set can hold.
  function automatic logic [CTRL_W-1:0] allowMask(input logic bank1Used);
    logic [CTRL_W-1:0] m;
    logic bank1Ok;
    m = {CTRL_W{1'b1}};
    bank1Ok = (TCM_B_PORTS == 2) && bank1Used;
    m[TCM_A_CHECK_ENABLE] = TCM_A_ECC && TCM_A_PRESENT;
    m[TCM_B_BANK0_CHECK_ENABLE] = TCM_B_ECC && (TCM_B_PORTS != 0);
    m[TCM_B_BANK1_CHECK_ENABLE] = TCM_B_ECC && bank1Ok;
    m[TCM_A_EXT_ERROR_ENABLE] = TCM_A_PRESENT;
    m[TCM_B_BANK0_EXT_ERROR_ENABLE] = TCM_B_PORTS != 0;
    m[TCM_B_BANK1_EXT_ERROR_ENABLE] = bank1Ok;
    m[TCM_A_RMW_ENABLE] = !TCM_A_ECC32;
    m[TCM_B_RMW_ENABLE] = !TCM_B_ECC32;
    m[SECONDARY_PERIPH_REGION_ENABLE] = SECONDARY_PORT;
    return m;
  endfunction

  // Masks a new control value; the bank-1 check bit follows bank 0 where bank 1 is allowed, else it is cleared.
  function automatic logic [CTRL_W-1:0] applyCtrl(input logic [CTRL_W-1:0] v,
                                                  input logic bank1Used);
    logic [CTRL_W-1:0] m;
    logic [CTRL_W-1:0] r;
    m = allowMask(bank1Used);
    r = v & m;
    r[TCM_B_BANK1_CHECK_ENABLE] = r[TCM_B_BANK0_CHECK_ENABLE]
                                  & m[TCM_B_BANK1_CHECK_ENABLE];
    return r;
  endfunction

  // Arrangement decode; locked mode only exists in redundant or split/lock builds.
  assign hasRedundant = (ARRANGEMENT == RCL_REDUNDANT) || (ARRANGEMENT == RCL_SPLITLOCK);
  assign isLocked = (ARRANGEMENT == RCL_REDUNDANT)
                    || ((ARRANGEMENT == RCL_SPLITLOCK) && st.lockedMode);
  assign cpu1Active = (ARRANGEMENT == RCL_TWIN)
                      || ((ARRANGEMENT == RCL_SPLITLOCK) && !st.lockedMode);
  assign apbWrite = psel && penable && pwrite;

  // Comparator watches core outputs, RAM requests and both coherency copies.
  assign mismatchNow = isLocked && ((cpu0Out != cpu1Out) || (cpu0RamReq != cpu1RamReq)
                       || (st.cohFunc != st.cohRed) || st.cmpSync[1]);

  // Region size is clamped to the legal range and the base forced onto that size.
  always_comb
  begin
    logic [32:0] sizeMask;
    sizeMask = '0;
    for (int c = 0; c < 2; c++)
    begin
      regionLog2[c] = st.strapLatched[c].regionLog2;
      if (regionLog2[c] < REGION_LOG2_MIN)
      begin
        regionLog2[c] = REGION_LOG2_MIN;
      end
      else if (regionLog2[c] > REGION_LOG2_MAX)
      begin
        regionLog2[c] = REGION_LOG2_MAX;
      end
      sizeMask = (33'h000000001 << regionLog2[c]) - 33'h000000001;
      regionBase[c] = {st.strapLatched[c].regionBase, 12'h000} & ~sizeMask[31:0];
    end
  end

  // Next-state logic for the whole block.
  always_comb
  begin
    next_st = st;
    // Pins come from tie-offs outside this clock, so each passes two flops.
    next_st.strapMeta = strapPins;
    next_st.strapSync = st.strapMeta;
    next_st.modeMeta = {lockClampSelect, splitModeSelect};
    next_st.modeSync = st.modeMeta;
    next_st.cmpMeta = {compareInB[CMP_TEST_BIT], compareInA[CMP_CLEAR_BIT]};
    next_st.cmpSync = st.cmpMeta;

    // When locked, both cores see the same inputs one cycle later, so lock-step is kept.
    next_st.cpu0CoreIn = cpu0In;
    next_st.cpu1CoreIn = isLocked ? cpu0In : (cpu1Active ? cpu1In : '0);
    next_st.groupOut0 = cpu0Out;
    next_st.groupOut1 = cpu1Active ? cpu1Out : '0;
    next_st.ram0Req = cpu0RamReq;
    next_st.ram1Req = cpu1Active ? cpu1RamReq : '0;
    next_st.cpu0RamRdata = ram0Rdata;
    next_st.cpu1RamRdata = isLocked ? ram0Rdata : (cpu1Active ? ram1Rdata : '0);

    // One coherency port feeds both caches; the CPUs never snoop each other.
    next_st.cohFunc = '{valid: coherencyValid, addr: coherencyAddr};
    next_st.cohRed = hasRedundant ? rcl_coh_t'{valid: coherencyValid, addr: coherencyAddr}
                                  : '0;

    // Sticky fault: a new mismatch wins over a clear in the same cycle.
    next_st.mismatch = mismatchNow;
    next_st.fault = mismatchNow || (st.fault && !st.cmpSync[0]);

    // Read data is captured in the setup cycle so it comes from a flop.
    if (psel && !penable)
    begin
      next_st.pslverr = 1'b0;
      case (paddr)
        OFF_CTRL0: next_st.prdata = {{(32-CTRL_W){1'b0}}, st.ctrl[0]};
        OFF_CTRL1: next_st.prdata = {{(32-CTRL_W){1'b0}}, st.ctrl[1]};
        OFF_STATUS: next_st.prdata = {27'h0000000, ARRANGEMENT, st.fault, st.mismatch, isLocked};
        OFF_REGION0: next_st.prdata = {regionBase[0][31:REGION_BASE_LSB], 6'h00, regionLog2[0]};
        OFF_REGION1: next_st.prdata = {regionBase[1][31:REGION_BASE_LSB], 6'h00, regionLog2[1]};
        default:
        begin
          next_st.prdata = 32'h00000000;
          next_st.pslverr = 1'b1;
        end
      endcase
    end

    // Sequencing of the reset load and software writes.
    case (st.phase)
      PH_RESET:
      begin
        // First cycle after release: fields take the latched pin values.
        for (int c = 0; c < 2; c++)
        begin
          next_st.ctrl[c] = applyCtrl(st.strapLatched[c].preset,
                                      st.strapLatched[c].bank1Used);
        end
        if (ARRANGEMENT == RCL_SINGLE)
        begin
          next_st.ctrl[1] = CTRL_RESET;
        end
        next_st.phase = PH_RUN;
      end
      PH_RUN:
      begin
        // Only a software write changes a field after the load.
        if (apbWrite && (paddr == OFF_CTRL0))
        begin
          next_st.ctrl[0] = applyCtrl(pwdata[CTRL_W-1:0], st.strapLatched[0].bank1Used);
        end
        if (apbWrite && (paddr == OFF_CTRL1) && (ARRANGEMENT != RCL_SINGLE))
        begin
          next_st.ctrl[1] = applyCtrl(pwdata[CTRL_W-1:0], st.strapLatched[1].bank1Used);
        end
      end
      default: next_st.phase = PH_RESET;
    endcase

    // Reset holds fields clear and keeps sampling pins and mode selects.
    if (reset)
    begin
      next_st.phase = PH_RESET;
      next_st.ctrl = '0;
      next_st.strapLatched = st.strapSync;
      next_st.lockedMode = st.modeSync[1] && !st.modeSync[0];
      next_st.mismatch = 1'b0;
      next_st.fault = 1'b0;
      next_st.cpu0CoreIn = '0;
      next_st.cpu1CoreIn = '0;
      next_st.groupOut0 = '0;
      next_st.groupOut1 = '0;
      next_st.ram0Req = '0;
      next_st.ram1Req = '0;
      next_st.cpu0RamRdata = '0;
      next_st.cpu1RamRdata = '0;
      next_st.cohFunc = '0;
      next_st.cohRed = '0;
      next_st.prdata = 32'h00000000;
      next_st.pslverr = 1'b0;
    end
  end

  // The whole state is one register.
  always_ff @(posedge clock)
  begin
    st <= next_st;
  end

  // Output drive; APB answers with no wait states.
  assign pready = psel && penable;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr && psel && penable;
  assign ctrlFields = st.ctrl;
  assign periphRegionBase = regionBase;
  assign periphRegionLog2 = regionLog2;
  assign lockedMode = isLocked;
  assign groupOut0 = st.groupOut0;
  assign groupOut1 = st.groupOut1;
  assign cpu0CoreIn = st.cpu0CoreIn;
  assign cpu1CoreIn = st.cpu1CoreIn;
  assign ram0Req = st.ram0Req;
  assign ram1Req = st.ram1Req;
  assign cpu0RamRdata = st.cpu0RamRdata;
  assign cpu1RamRdata = st.cpu1RamRdata;
  assign snoopValid = {st.cohFunc.valid && (cpu1Active || isLocked), st.cohFunc.valid};
  assign snoopAddr = st.cohFunc.addr;

  // Outward status is sent dual-rail so a stuck wire shows up at the far end.
  always_comb
  begin
    compareOutA = 8'h00;
    compareOutA[CMP_OUT_LOCKED] = isLocked;
    compareOutA[CMP_OUT_MISMATCH] = st.mismatch;
    compareOutA[CMP_OUT_FAULT] = st.fault;
    compareOutB = ~compareOutA;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_endian_preset: assert property ((st.phase == PH_RESET) |=>
    st.ctrl[0][EXCEPTION_ENDIAN_BIT] == $past(st.strapLatched[0].preset[EXCEPTION_ENDIAN_BIT]))
    else $error("Exception endianness not loaded from pin.");
  a_state_preset: assert property ((st.phase == PH_RESET) |=>
    st.ctrl[1][EXCEPTION_STATE_BIT] ==
    ($past(st.strapLatched[1].preset[EXCEPTION_STATE_BIT]) && (ARRANGEMENT != RCL_SINGLE)))
    else $error("Exception state not loaded from pin.");
  a_vector_preset: assert property ((st.phase == PH_RESET) |=>
    st.ctrl[0][HIGH_VECTORS_BIT] == $past(st.strapLatched[0].preset[HIGH_VECTORS_BIT]))
    else $error("Vector location not loaded from pin.");
  a_bank_check_joined: assert property ((st.phase == PH_RUN) |->
    !st.ctrl[0][TCM_B_BANK1_CHECK_ENABLE] || st.ctrl[0][TCM_B_BANK0_CHECK_ENABLE])
    else $error("Bank 1 check enabled without bank 0.");
  a_enable_gated: assert property ((st.phase == PH_RUN) |->
    (st.ctrl[0] & ~allowMask(st.strapLatched[0].bank1Used)) == '0)
    else $error("Control bit set that the build does not allow.");
  a_rmw_blocked: assert property (TCM_A_ECC32 |-> !st.ctrl[0][TCM_A_RMW_ENABLE])
    else $error("Read-modify-write enabled with word ECC.");
  a_secondary_gated: assert property (!SECONDARY_PORT |->
    !st.ctrl[1][SECONDARY_PERIPH_REGION_ENABLE])
    else $error("Secondary region enabled without the port.");
  a_cpu_separate: assert property (st.phase == PH_RUN && apbWrite && paddr == OFF_CTRL0
    |=> $stable(st.ctrl[1]))
    else $error("Write to one CPU changed the other.");
  a_region_aligned: assert property (
    (regionBase[0] & ((32'h00000001 << regionLog2[0][4:0]) - 32'h00000001)) == '0
    || regionLog2[0] == REGION_LOG2_MAX)
    else $error("Region base not aligned to its size.");
  a_lockstep_inputs: assert property (isLocked |=> cpu1CoreIn == $past(cpu0In))
    else $error("Redundant copy saw different inputs.");
  a_func_drives: assert property (isLocked |=>
    groupOut1 == '0 && ram1Req == '0 && groupOut0 == $past(cpu0Out))
    else $error("Redundant copy reached an output.");
  a_fault_caught: assert property (mismatchNow |=> st.fault ##1 st.fault)
    else $error("Mismatch not held as a fault.");
  a_mode_held: assert property ((st.phase == PH_RUN) |=> $stable(st.lockedMode))
    else $error("Mode changed outside power-on reset.");
  a_ctrl_sw_only: assert property (st.phase == PH_RUN && !apbWrite |=> $stable(st.ctrl))
    else $error("Control field changed without a write.");

  c_locked_fault: cover property (isLocked && mismatchNow ##1 st.fault);
  c_split_snoop: cover property (cpu1Active && coherencyValid ##1 snoopValid == 2'b11);
  c_ctrl_write: cover property ((st.phase == PH_RUN) && apbWrite && (paddr == OFF_CTRL1));
  c_fault_cleared: cover property (st.fault ##1 !st.fault);

endmodule

/* File: tb/rcl_sys_model.sv */
// Partner model: tie-off pins and two behavioural cores with their RAMs.
`timescale 1ns/1ps
module rcl_sys_model import rcl_pkg::*; #(
  parameter logic [31:0] CORE_KEY = 32'h5a5a_0f0f,
  parameter logic [63:0] RAM_KEY = 64'h0123_4567_89ab_cdef
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Requests from the bench.
  input wire rcl_strap_t [1:0] wantStraps,
  input wire logic wantSplit,
  input wire logic wantClamp,
  input wire logic lateChange,
  input wire logic faultInject,
  // Core and RAM side of the group.
  input wire logic [31:0] cpu0CoreIn,
  input wire logic [31:0] cpu1CoreIn,
  input wire logic [63:0] ram0Req,
  input wire logic [63:0] ram1Req,
  // Pins and answers back to the group.
  output rcl_strap_t [1:0] strapPins,
  output logic splitModeSelect,
  output logic lockClampSelect,
  output logic [31:0] cpu0Out,
  output logic [31:0] cpu1Out,
  output logic [63:0] ram0Rdata,
  output logic [63:0] ram1Rdata
);
  rcl_strap_t [1:0] fixed;
  // Second-memory base as this system ties it: aligned to the 128 KB both banks span.
  localparam logic [31:0] TCM_B_BASE = 32'h0002_0000;

  // Presets lose their bank-1 bits where bank 1 is unused, and bases are aligned before they reach the pins.
  always_comb
  begin
    fixed = wantStraps;
    for (int i = 0; i < 2; i++)
    begin
      if (!fixed[i].bank1Used)
        fixed[i].preset = fixed[i].preset & 13'h1edf;
      fixed[i].regionBase &= ~((20'h1 << (fixed[i].regionLog2 - 6'h0c)) - 20'h1);
    end
  end

  // Pins move only while reset is held; a late change is a deliberate fault.
  // They are unknown until the first edge, which falls well inside reset.
  always @(posedge clock)
  begin
    if (reset || lateChange)
    begin
      strapPins <= fixed;
      splitModeSelect <= wantSplit;
      lockClampSelect <= wantClamp;
    end
  end

  // Cores answer at once; a fault flips one bit of the second core for as long as it is held.
  assign cpu0Out = cpu0CoreIn ^ CORE_KEY;
  assign cpu1Out = cpu1CoreIn ^ CORE_KEY ^ {31'h0, faultInject};
  assign ram0Rdata = ram0Req ^ RAM_KEY;
  assign ram1Rdata = ram1Req ^ RAM_KEY;
endmodule

/* File: tb/test_rcl_top.sv */
// Self-checking testbench for the reset configuration and lock-step block.
`timescale 1ns/1ps
module test_rcl_top import rcl_pkg::*; ();
  localparam logic [31:0] KEY = 32'h5a5a_0f0f;
  localparam logic [63:0] RKEY = 64'h0123_4567_89ab_cdef;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, lockedMode;
  logic splitModeSelect, lockClampSelect, wantSplit, wantClamp, lateChange;
  logic faultInject, coherencyValid;
  logic [7:0] paddr, compareInA, compareInB, compareOutA, compareOutB;
  logic [31:0] pwdata, prdata, cpu0In, cpu1In, groupOut0, groupOut1, cpu0CoreIn;
  logic [31:0] cpu1CoreIn, cpu0Out, cpu1Out, coherencyAddr, snoopAddr;
  logic [63:0] cpu0RamReq, cpu1RamReq, ram0Req, ram1Req, ram0Rdata, ram1Rdata;
  logic [63:0] cpu0RamRdata, cpu1RamRdata;
  logic [1:0] snoopValid;
  logic [1:0][CTRL_W-1:0] ctrlFields;
  logic [1:0][31:0] periphRegionBase;
  logic [1:0][5:0] periphRegionLog2;
  rcl_strap_t [1:0] strapPins, wantStraps;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

  rcl_top DUT (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .strapPins(strapPins), .splitModeSelect(splitModeSelect),
    .lockClampSelect(lockClampSelect), .ctrlFields(ctrlFields),
    .periphRegionBase(periphRegionBase), .periphRegionLog2(periphRegionLog2),
    .lockedMode(lockedMode), .cpu0In(cpu0In), .cpu1In(cpu1In), .groupOut0(groupOut0),
    .groupOut1(groupOut1), .cpu0CoreIn(cpu0CoreIn), .cpu1CoreIn(cpu1CoreIn),
    .cpu0Out(cpu0Out), .cpu1Out(cpu1Out), .cpu0RamReq(cpu0RamReq), .cpu1RamReq(cpu1RamReq),
    .ram0Req(ram0Req), .ram1Req(ram1Req), .ram0Rdata(ram0Rdata), .ram1Rdata(ram1Rdata),
    .cpu0RamRdata(cpu0RamRdata), .cpu1RamRdata(cpu1RamRdata), .compareInA(compareInA),
    .compareInB(compareInB), .compareOutA(compareOutA), .compareOutB(compareOutB),
    .coherencyValid(coherencyValid), .coherencyAddr(coherencyAddr),
    .snoopValid(snoopValid), .snoopAddr(snoopAddr));

  rcl_sys_model #(.CORE_KEY(KEY), .RAM_KEY(RKEY)) sysModel (.clock(clock), .reset(reset),
    .wantStraps(wantStraps), .wantSplit(wantSplit), .wantClamp(wantClamp),
    .lateChange(lateChange), .faultInject(faultInject), .cpu0CoreIn(cpu0CoreIn),
    .cpu1CoreIn(cpu1CoreIn), .ram0Req(ram0Req), .ram1Req(ram1Req), .strapPins(strapPins),
    .splitModeSelect(splitModeSelect), .lockClampSelect(lockClampSelect),
    .cpu0Out(cpu0Out), .cpu1Out(cpu1Out), .ram0Rdata(ram0Rdata), .ram1Rdata(ram1Rdata));

  // Free-running clock at 100 MHz.
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // A hang is cut short well beyond the fewer than a hundred cycles the run needs.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic check_val(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits n rising edges and stops at the falling edge, where registered outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                     output logic [31:0] rdata, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    logic e;
    apb(1'b1, addr, data, d, e);
  endtask

  task automatic reg_read(input logic [7:0] addr, input logic [31:0] exp, input logic expErr);
    logic [31:0] d;
    logic e;
    apb(1'b0, addr, 32'h0, d, e);
    check_val("read data", 64'(exp), 64'(d));
    check_val("slave error", 64'(expErr), 64'(e));
  endtask

  // Holds the group in reset while the wanted mode and straps settle on the pins.
  task automatic do_reset(input logic split, input logic clamp);
    @(posedge clock);
    wantSplit <= split;
    wantClamp <= clamp;
    reset <= 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    tick(3);
  endtask

  initial
  begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'h0, 8'h00, 32'h0};
    {compareInA, compareInB, coherencyValid, coherencyAddr} = '0;
    {lateChange, faultInject, wantSplit, wantClamp} = 4'h0;
    cpu0In = 32'h1111_2222;
    cpu1In = 32'h3333_4444;
    cpu0RamReq = 64'h0f0f_0000_ffff_1234;
    cpu1RamReq = cpu0RamReq; // Lock-step cores ask for the same RAM word.
    wantStraps[0] = '{13'h1fdf, 1'b1, 6'h0d, 20'h12344};
    wantStraps[1] = '{13'h1fff, 1'b1, 6'h14, 20'hab300};
    // Locked mode with every preset but CPU0's bank-1 check set, bank 0 check alone requesting both banks.
    do_reset(1'b0, 1'b1);
    check_val("ctrl0 preset", 64'(13'h1fff), 64'(ctrlFields[0]));
    check_val("region0 base", 64'(32'h1234_4000), 64'(periphRegionBase[0]));
    check_val("region0 size", 64'(6'h0d), 64'(periphRegionLog2[0]));
    check_val("locked", 64'(1'b1), 64'(lockedMode));
    check_val("compare out a", 64'(8'h01), 64'(compareOutA));
    check_val("compare out b", 64'(8'hfe), 64'(compareOutB));
    reg_read(OFF_STATUS, 32'h19, 1'b0);
    @(posedge clock) {coherencyValid, coherencyAddr} <= {1'b1, 32'h8000_0040};
    tick(3);
    check_val("core1 input", 64'(32'h1111_2222), 64'(cpu1CoreIn));
    check_val("core0 input", 64'(32'h1111_2222), 64'(cpu0CoreIn));
    check_val("core0 ram data", cpu0RamReq ^ RKEY, cpu0RamRdata);
    check_val("group out 0", 64'(32'h1111_2222 ^ KEY), 64'(groupOut0));
    check_val("group out 1", 64'(32'h0), 64'(groupOut1));
    check_val("ram1 request", 64'h0, ram1Req);
    check_val("ram0 request", cpu0RamReq, ram0Req);
    check_val("core1 ram data", cpu0RamReq ^ RKEY, cpu1RamRdata);
    check_val("snoop valid", 64'(2'b11), 64'(snoopValid));
    check_val("snoop addr", 64'(32'h8000_0040), 64'(snoopAddr));
    check_val("no false mismatch", 64'(8'h01), 64'(compareOutA));
    // A one-cycle difference gives one mismatch cycle and a sticky fault.
    @(posedge clock) faultInject <= 1'b1;
    @(posedge clock) faultInject <= 1'b0;
    @(negedge clock);
    check_val("mismatch", 64'(8'h07), 64'(compareOutA));
    tick(1);
    check_val("sticky fault", 64'(8'h05), 64'(compareOutA));
    reg_read(OFF_STATUS, 32'h1d, 1'b0);
    @(posedge clock) compareInA <= 8'h01;
    tick(5);
    check_val("fault cleared", 64'(8'h01), 64'(compareOutA));
    @(posedge clock) {compareInA, compareInB} <= {8'h00, 8'h01};
    tick(5);
    check_val("forced fault", 64'(1'b1), 64'(compareOutA[2]));
    @(posedge clock) compareInB <= 8'h00;
    // Software rewrites the preset fields; bit 4 alone drags bit 5 with it.
    reg_write(OFF_CTRL0, 32'h10);
    tick(1);
    check_val("ctrl0 write", 64'(13'h0030), 64'(ctrlFields[0]));
    reg_read(OFF_CTRL0, 32'h30, 1'b0);
    reg_read(8'h20, 32'h0, 1'b1);
    reg_read(OFF_REGION0, 32'h1234_400d, 1'b0);
    // Pins moved outside reset must not reach the mode or the latched straps.
    wantStraps[0].regionLog2 <= 6'h10;
    @(posedge clock) {lateChange, wantSplit, wantClamp} <= 3'b110;
    tick(5);
    check_val("late mode", 64'(1'b1), 64'(lockedMode));
    check_val("late strap", 64'(6'h0d), 64'(periphRegionLog2[0]));
    @(posedge clock) lateChange <= 1'b0;
    // Split mode: two CPUs with their own presets, bank 1 unused on CPU1.
    wantStraps[0] <= '{13'h0005, 1'b1, 6'h0d, 20'h12344};
    wantStraps[1] <= '{13'h01b0, 1'b0, 6'h14, 20'hab300};
    do_reset(1'b1, 1'b0);
    cpu1RamReq = 64'h7777_8888_9999_aaaa;
    check_val("ctrl0 split", 64'(13'h0005), 64'(ctrlFields[0]));
    check_val("ctrl1 split", 64'(13'h0090), 64'(ctrlFields[1]));
    check_val("unlocked", 64'(1'b0), 64'(lockedMode));
    check_val("region1 base", 64'(32'hab30_0000), 64'(periphRegionBase[1]));
    check_val("region1 size", 64'(6'h14), 64'(periphRegionLog2[1]));
    reg_write(OFF_CTRL1, 32'h1fff);
    tick(1);
    check_val("ctrl1 masked", 64'(13'h1edf), 64'(ctrlFields[1]));
    check_val("ctrl0 kept", 64'(13'h0005), 64'(ctrlFields[0]));
    check_val("core1 own input", 64'(32'h3333_4444), 64'(cpu1CoreIn));
    check_val("group out 1", 64'(32'h3333_4444 ^ KEY), 64'(groupOut1));
    check_val("ram1 own request", cpu1RamReq, ram1Req);
    check_val("ram1 own data", cpu1RamReq ^ RKEY, cpu1RamRdata);
    check_val("snoop both", 64'(2'b11), 64'(snoopValid));
    @(posedge clock) faultInject <= 1'b1;
    @(posedge clock) faultInject <= 1'b0;
    tick(1);
    check_val("no split compare", 64'(8'h00), 64'(compareOutA));
    reg_read(OFF_STATUS, 32'h18, 1'b0);
    report_and_stop();
  end
endmodule
